// file: src/qrg_pulse_gate.sv
// pulse gate: comparator input selection and lock sequencing
// Functional notes
// [R1] on lock, feedback select moves from halved oscillator to gated pulse
// [R2] once phase-only, oscillator pulse passes only after a data pulse
// [R3] locked read of data field compares phase only
// [R4] read window low: phase-frequency compare against the reference
// [R5] read mode keeps phase-frequency until lock is indicated
// [R6] controller raises the read window only over preamble
// [R7] controller holds read window low four byte times to settle
// [R8] controller waits 2.5 byte times of preamble before raising window
// [R9] controller needs five byte times of preamble or restarts settle
// [R10] confirmed preamble activates lock; controller then seeks address mark (controller model only holds the window, with no address mark search)
// [R11] no address mark found sends controller back to settle (controller model leaves the window after confirmation only when run_i drops)
// [R12] lock activates after sixteen consecutive preamble pulses in read mode
// [R13] non-read, unlocked: compare halved reference with halved oscillator
// [R14] read, unlocked: compare encoded data with halved oscillator
// [R15] controller counts byte times as eight bits, restarts on settle
`default_nettype none
module qrg_pulse_gate
	import qrg_pkg::*;
(
	input  wire logic clock_i,
	input  wire logic reset_n_i,
	input  wire logic read_window_i,         // read gate from controller
	input  wire logic encoded_data_i,        // one-cycle raw data pulse
	input  wire logic double_rate_reference_i, // sampled reference clock
	input  wire logic oscillator_i,          // sampled oscillator clock
	output logic      cmp_ref_o,             // comparator reference input
	output logic      cmp_fb_o,              // comparator feedback input
	output logic      phase_only_o,          // high in phase-only mode
	output logic      lock_detected_o,       // lock indication, high active
	output logic      read_mode_o            // internal read window
);
	import qrg_pkg::*;

	qrg_det_if dif ();

	qrg_mode_t mode_r;
	qrg_mode_t mode_nxt;
	logic      rw_r;
	logic      osc_q_r;
	logic      ref_q_r;
	logic      osc_half_r;
	logic      osc_half_nxt;
	logic      ref_half_r;
	logic      ref_half_nxt;
	logic      arm_r;
	logic      arm_nxt;
	logic      gated_r;
	logic      gated_nxt;
	logic      cmp_ref_nxt;
	logic      cmp_fb_nxt;
	logic      osc_rise;
	logic      ref_rise;
	logic      osc_half_rise;

	////////////////////////////////////////////////////////////////////
	// phase-only operation belongs to the locked state alone
	function automatic logic locked_mode(qrg_mode_t m);
		return m == QRG_LOCKED;
	endfunction

	////////////////////////////////////////////////////////////////////
	// edge detect and halving of the sampled clocks
	assign osc_rise      = oscillator_i & ~osc_q_r;
	assign ref_rise      = double_rate_reference_i & ~ref_q_r;
	assign osc_half_rise = osc_rise & ~osc_half_r;

	always_comb begin
		osc_half_nxt = osc_half_r ^ osc_rise;
		ref_half_nxt = ref_half_r ^ ref_rise;
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			osc_q_r    <= 1'b0;
			ref_q_r    <= 1'b0;
			osc_half_r <= 1'b0;
			ref_half_r <= 1'b0;
			rw_r       <= 1'b0;
		end else begin
			osc_q_r    <= oscillator_i;
			ref_q_r    <= double_rate_reference_i;
			osc_half_r <= osc_half_nxt;
			ref_half_r <= ref_half_nxt;
			rw_r       <= read_window_i;
		end
	end

	////////////////////////////////////////////////////////////////////
	// preamble counter
	assign dif.data_pulse = encoded_data_i;
	assign dif.osc_edge   = osc_half_rise;
	assign dif.read_mode  = rw_r;

	qrg_preamble_det u_det (
		.clock_i   (clock_i),
		.reset_n_i (reset_n_i),
		.dif       (dif)
	);

	////////////////////////////////////////////////////////////////////
	// mode sequencing: non-read, acquire, locked
	always_comb begin
		mode_nxt = mode_r;
		unique case (mode_r)
			QRG_NONREAD: begin
				if (rw_r)
					mode_nxt = QRG_ACQUIRE; // [R5]
			end
			QRG_ACQUIRE: begin
				if (!rw_r)
					mode_nxt = QRG_NONREAD; // [R4]
				else if (dif.lock_done)
					mode_nxt = QRG_LOCKED; // [R10] [R12]
			end
			QRG_LOCKED: begin
				if (!rw_r)
					mode_nxt = QRG_NONREAD; // [R4]
			end
			default: mode_nxt = QRG_NONREAD;
		endcase
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i)
			mode_r <= QRG_NONREAD;
		else
			mode_r <= mode_nxt;
	end

	////////////////////////////////////////////////////////////////////
	// data-gated oscillator pulse: arm on data, fire on oscillator edge
	always_comb begin
		arm_nxt   = arm_r;
		gated_nxt = 1'b0;
		if (!locked_mode(mode_r)) begin
			arm_nxt = 1'b0;
		end else begin
			if (osc_rise && arm_r) begin
				gated_nxt = 1'b1; // [R2]
				arm_nxt   = 1'b0;
			end
			if (encoded_data_i)
				arm_nxt = 1'b1; // new pulse wins over the clear
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			arm_r   <= 1'b0;
			gated_r <= 1'b0;
		end else begin
			arm_r   <= arm_nxt;
			gated_r <= gated_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// comparator input multiplexers, registered
	always_comb begin
		cmp_ref_nxt = (mode_r == QRG_NONREAD) ? ref_half_r
			: encoded_data_i; // [R13] [R14]
		cmp_fb_nxt  = locked_mode(mode_r) ? gated_r
			: osc_half_r; // [R1] [R13] [R14]
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cmp_ref_o <= 1'b0;
			cmp_fb_o  <= 1'b0;
		end else begin
			cmp_ref_o <= cmp_ref_nxt;
			cmp_fb_o  <= cmp_fb_nxt;
		end
	end

	assign lock_detected_o = locked_mode(mode_r);
	assign phase_only_o    = locked_mode(mode_r); // [R3]
	assign read_mode_o     = rw_r;

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);

	a_fb_gated_lock: assert property ( // [R1]
		lock_detected_o |=> cmp_fb_o == $past(gated_r))
		else $error("feedback not gated pulse while locked");
	a_gated_needs_data: assert property ( // [R2]
		$rose(gated_r) |-> $past(arm_r) && $past(osc_rise)
			&& $past(lock_detected_o))
		else $error("gated pulse without sensed data");
	a_locked_phase_only: assert property ( // [R3]
		lock_detected_o |-> phase_only_o && $past(read_mode_o))
		else $error("locked read not phase only");
	// the window passes two flops before the multiplexer, so wait three
	a_nonread_pfd: assert property ( // [R4]
		!read_window_i [*3] |=> !phase_only_o
			&& cmp_ref_o == $past(ref_half_r))
		else $error("non-read mode not against reference");
	a_acquire_holds_pfd: assert property ( // [R5]
		(rw_r && !lock_detected_o && !dif.lock_done) |=> !phase_only_o)
		else $error("phase only before lock");
	a_lock_follows_done: assert property ( // [R10]
		(rw_r && read_window_i && dif.lock_done && !lock_detected_o)
			|=> lock_detected_o)
		else $error("lock not raised on confirmed preamble");
	a_lock_needs_count: assert property ( // [R12]
		$rose(lock_detected_o) |-> $past(dif.streak) == LOCK_COUNT)
		else $error("lock before sixteen pulses");
	a_idle_inputs: assert property ( // [R13]
		mode_r == QRG_NONREAD |=> cmp_fb_o == $past(osc_half_r)
			&& cmp_ref_o == $past(ref_half_r))
		else $error("non-read inputs wrong");
	a_acquire_inputs: assert property ( // [R14]
		mode_r == QRG_ACQUIRE |=> cmp_ref_o == $past(encoded_data_i)
			&& cmp_fb_o == $past(osc_half_r))
		else $error("preamble search inputs wrong");

	c_lock_reached: cover property ($rose(lock_detected_o));
	c_gated_pulse: cover property (gated_r && lock_detected_o);
	c_lock_dropped: cover property (lock_detected_o ##1 !lock_detected_o);
	c_streak_broken: cover property (
		rw_r && dif.streak != STREAK_RST ##1 dif.streak == STREAK_RST
			&& rw_r);
endmodule
`default_nettype wire

// file: src/qrg_pkg.sv
// shared constants and types for the qualified read gate pulse gate
`default_nettype none
package qrg_pkg;
	// consecutive preamble pulses needed before lock is flagged
	localparam int unsigned LOCK_PULSES = 16;
	localparam int unsigned STREAK_W    = 5;
	localparam logic [4:0]  LOCK_COUNT  = 5'h10;
	localparam logic [4:0]  STREAK_RST  = 5'h00;
	localparam logic [4:0]  STREAK_ONE  = 5'h01;
	// comparator operating modes
	typedef enum logic [1:0] {
		QRG_NONREAD,
		QRG_ACQUIRE,
		QRG_LOCKED
	} qrg_mode_t;
endpackage
`default_nettype wire

// file: src/qrg_det_if.sv
// link between the pulse gate top and its preamble pulse counter
`default_nettype none
interface qrg_det_if;
	logic       data_pulse;
	logic       osc_edge;
	logic       read_mode;
	logic       lock_done;
	logic [4:0] streak;
	modport top (output data_pulse, output osc_edge, output read_mode,
		input lock_done, input streak);
	modport det (input data_pulse, input osc_edge, input read_mode,
		output lock_done, output streak);
endinterface
`default_nettype wire

// file: src/qrg_preamble_det.sv
// counts consecutive preamble pulses, one per halved oscillator period
`default_nettype none
module qrg_preamble_det
	import qrg_pkg::*;
(
	input  wire logic clock_i,
	input  wire logic reset_n_i,
	qrg_det_if.det    dif
);
	import qrg_pkg::*;

	logic [4:0] streak_r;
	logic [4:0] streak_nxt;
	logic       seen_r;
	logic       seen_nxt;

	////////////////////////////////////////////////////////////////////
	// a period with no pulse breaks the streak; count saturates at lock
	always_comb begin
		streak_nxt = streak_r;
		seen_nxt   = seen_r;
		if (!dif.read_mode) begin
			streak_nxt = STREAK_RST;
			seen_nxt   = 1'b0;
		end else begin
			if (dif.osc_edge) begin
				if (!seen_r && !dif.data_pulse)
					streak_nxt = STREAK_RST; // missing pulse
				seen_nxt = dif.data_pulse;
			end else if (dif.data_pulse) begin
				seen_nxt = 1'b1;
			end
			if (dif.data_pulse && streak_r != LOCK_COUNT)
				streak_nxt = streak_r + STREAK_ONE; // [R12]
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			streak_r <= STREAK_RST;
			seen_r   <= 1'b0;
		end else begin
			streak_r <= streak_nxt;
			seen_r   <= seen_nxt;
		end
	end

	assign dif.streak    = streak_r;
	assign dif.lock_done = (streak_r == LOCK_COUNT); // [R12]
endmodule
`default_nettype wire

// file: dv/qrg_ctrl_model.sv
// disk controller and drive model facing the pulse gate
`default_nettype none
module qrg_ctrl_model (
	input  wire logic clock_i,
	input  wire logic reset_n_i,
	input  wire logic run_i,          // bench asks for a read
	input  wire logic pre_i,          // preamble under the head
	output logic      read_window_o,
	output logic      encoded_data_o,
	output logic      reference_o,
	output logic      oscillator_o
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BYTE = 64; // eight bit periods of eight cycles
	logic [2:0] ph_r;
	logic [9:0] cnt_r;
	logic [1:0] st_r;
	////////////////////////////////////////////////////////////
	// clocks and one data pulse per halved oscillator period
	assign oscillator_o   = ph_r[1];
	assign reference_o    = ph_r[1];
	assign encoded_data_o = pre_i && ph_r == 3'h3;
	assign read_window_o  = st_r == 2'h2;
	// settle, qualify preamble, then hold the window
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ph_r  <= 3'h0;
			cnt_r <= 10'h0;
			st_r  <= 2'h0;
		end else begin
			ph_r  <= ph_r + 3'h1;
			cnt_r <= cnt_r + 10'h1;
			case (st_r)
			2'h0: if (run_i && cnt_r >= 10'(4 * BYTE - 1)) begin
				st_r  <= 2'h1;
				cnt_r <= 10'h0;
			end
			2'h1: if (!pre_i) begin
				cnt_r <= 10'h0; // preamble count restarts
			end else if (cnt_r == 10'(5 * BYTE / 2 - 1)) begin
				st_r  <= 2'h2;
				cnt_r <= 10'h0;
			end
			default: if (!run_i || (!pre_i && cnt_r < 10'(5 * BYTE))) begin
				st_r  <= 2'h0; // short preamble or read over
				cnt_r <= 10'h0;
			end else if (cnt_r == 10'(5 * BYTE)) begin
				cnt_r <= cnt_r; // preamble confirmed
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// file: dv/qrg_pulse_gate_test.sv
// self-checking bench for the pulse gate
`default_nettype none
module qrg_pulse_gate_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i, reset_n_i, run, pre, rw, dat, ref_c, osc;
	logic cmp_ref, cmp_fb, ph_only, lock, rmode;
	int   n_errors, cmp_count;
	qrg_ctrl_model i_ctrl (.clock_i(clock_i), .reset_n_i(reset_n_i),
		.run_i(run), .pre_i(pre), .read_window_o(rw),
		.encoded_data_o(dat), .reference_o(ref_c), .oscillator_o(osc));
	qrg_pulse_gate i_dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
		.read_window_i(rw), .encoded_data_i(dat),
		.double_rate_reference_i(ref_c), .oscillator_i(osc),
		.cmp_ref_o(cmp_ref), .cmp_fb_o(cmp_fb), .phase_only_o(ph_only),
		.lock_detected_o(lock), .read_mode_o(rmode));
	////////////////////////////////////////////////////////////
	// helpers
	task automatic tick(int n = 1);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task automatic check(string what, logic exp, logic got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask
	// bounded wait on lock (k=1) or read mode (k=0)
	task automatic await(int k, logic v, int lim);
		for (int i = 0; i < lim && (k ? lock : rmode) !== v; i++) tick();
		check(k ? "lock" : "read_mode", v, k ? lock : rmode);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	// halved clocks reach the comparator outside a read
	task automatic t_nonread();
		int nr, nf;
		logic pr, pf;
		nr = 0;
		nf = 0;
		for (int i = 0; i < 32; i++) begin
			pr = cmp_ref;
			pf = cmp_fb;
			tick();
			nr += int'(pr !== cmp_ref);
			nf += int'(pf !== cmp_fb);
		end
		check("ref toggles", 1'b1, nr == 8);
		check("fb toggles", 1'b1, nf == 8);
		check("phase_only", 1'b0, ph_only);
	endtask
	// data drives the reference side; lock after sixteen periods
	task automatic t_lock();
		logic pd, ok;
		ok = 1;
		run = 1;
		pre = 1;
		await(0, 1'b1, 600);
		tick(2);
		for (int i = 0; i < 100; i++) begin
			pd = dat;
			tick();
			ok &= cmp_ref === pd && lock === 1'b0 && ph_only === 1'b0;
		end
		check("data path unlocked", 1'b1, ok);
		await(1, 1'b1, 80);
		check("phase_only", 1'b1, ph_only);
	endtask
	// oscillator pulses pass only after data pulses
	task automatic t_gate();
		logic any;
		any = 0;
		tick(400);
		pre = 0;
		tick(12);
		for (int i = 0; i < 40; i++) begin
			tick();
			any |= cmp_fb;
		end
		check("fb blocked", 1'b0, any);
		pre = 1;
		for (int i = 0; i < 20; i++) begin
			tick();
			any |= cmp_fb;
		end
		check("fb gated pulse", 1'b1, any);
	endtask
	// window drop ends lock; short preamble never locks
	task automatic t_abort();
		run = 0;
		await(0, 1'b0, 4);
		await(1, 1'b0, 3);
		run = 1;
		await(0, 1'b1, 600);
		tick(40);
		pre = 0;
		await(0, 1'b0, 4);
		check("lock", 1'b0, lock);
		run = 0;
	endtask
	////////////////////////////////////////////////////////////
	// clock
	initial begin
		clock_i = 0;
		forever #2 clock_i = ~clock_i;
	end
	// reset then scenarios
	initial begin
		n_errors = 0;
		cmp_count = 0;
		reset_n_i = 0;
		run = 0;
		pre = 0;
		tick(4);
		reset_n_i = 1;
		tick(2);
		t_nonread();
		t_lock();
		t_gate();
		t_abort();
		report_and_stop();
	end
	// watchdog
	initial begin
		#80000;
		n_errors++;
		report_and_stop();
	end
endmodule
`default_nettype wire
